// File: design/spd_serial_rx.sv
`timescale 1ns/10ps
module spd_serial_rx (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Sleep control
    input  wire logic        sleep_n_input,
    // Three-wire serial pins
    input  wire logic        ser_clk,
    input  wire logic        ser_data,
    input  wire logic        ser_latch,
    // Received word
    output logic             word_vld,
    output logic             word_sel,
    output logic [15:0]      word_data
);

    // =========================================================================
    // State
    typedef struct packed {
        logic        sck_q;
        logic        lat_q;
        logic [16:0] shreg;
        logic [4:0]  cnt;
        logic        vld;
    } spd_rx_t;

    spd_rx_t st_ff;
    spd_rx_t nxt_st;

    // Shift on serial clock rise, deliver on latch rise once a full frame is in.
    // A short or long frame is dropped rather than guessed at.
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sck_q = ser_clk;
        nxt_st.lat_q = ser_latch;
        nxt_st.vld   = 1'b0;
        if (ser_clk && !st_ff.sck_q) begin
            nxt_st.shreg = {st_ff.shreg[15:0], ser_data};
            if (st_ff.cnt != 5'h1F) begin
                nxt_st.cnt = st_ff.cnt + 5'h01;
            end
        end
        if (ser_latch && !st_ff.lat_q) begin
            nxt_st.vld = (st_ff.cnt == 5'(spd_pkg::FRAME_W)) && sleep_n_input;
            nxt_st.cnt = 5'h00;
        end
        if (!sleep_n_input) begin
            nxt_st.cnt = 5'h00;
        end
    end

    // Single state register.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign word_vld  = st_ff.vld;
    assign word_sel  = st_ff.shreg[16];
    assign word_data = st_ff.shreg[15:0];

    a_write_gate: assert property (@(posedge clk) disable iff (rst)
        word_vld |-> $past(sleep_n_input))
        else $error("word delivered while sleep was low");

endmodule : spd_serial_rx

// File: design/spd_top.sv
`timescale 1ns/10ps
module spd_top #(
    parameter int unsigned RST_PULSE_CYC = spd_pkg::RST_PULSE_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Device control and events
    input  wire logic        sleep_n_input,
    input  wire logic        thermal_shutdown,
    input  wire logic        osc_clk_in,
    // Three-wire serial pins
    input  wire logic        ser_clk,
    input  wire logic        ser_data,
    input  wire logic        ser_latch,
    // Stepper drive settings
    output logic [1:0]       torque_sel,
    output logic [1:0]       decay_a_mode,
    output logic [1:0]       decay_b_mode,
    output logic [3:0]       current_a_level,
    output logic [3:0]       current_b_level,
    // Bridge direction controls
    output logic             winding_a_pos_out,
    output logic             winding_a_neg_out,
    output logic             winding_b_pos_out,
    output logic             winding_b_neg_out,
    output logic             motor_bridge_en,
    // Supervisory outputs
    output logic             buck_enable,
    output logic             reset_out_n,
    output logic [2:0]       test_select,
    output logic             dcdc_osc_monitor_pin,
    output logic             motor_osc_monitor_pin
);

    // =========================================================================
    // Helpers
    // True for the two test modes that keep a thermal trip away from the supply and both registers.
    function automatic logic is_tsd_ctrl(input logic [2:0] sel);
        return (sel == spd_pkg::TSEL_TSD1) || (sel == spd_pkg::TSEL_TSD2);
    endfunction : is_tsd_ctrl

    // =========================================================================
    // Serial receiver
    logic        word_vld;
    logic        word_sel;
    logic [15:0] word_data;

    spd_serial_rx u_rx (
        .clk           (clk),
        .rst           (rst),
        .sleep_n_input (sleep_n_input),
        .ser_clk       (ser_clk),
        .ser_data      (ser_data),
        .ser_latch     (ser_latch),
        .word_vld      (word_vld),
        .word_sel      (word_sel),
        .word_data     (word_data)
    );

    // =========================================================================
    // State
    typedef struct packed {
        logic [15:0] param;
        logic [2:0]  tsel;
        logic        tsd_q;
        logic        motor_sd;
        logic        buck_en;
        logic [20:0] pulse_cnt;
        logic        rst_n;
        logic        osc_mon;
        logic [1:0]  torque;
        logic [1:0]  decay_a;
        logic [1:0]  decay_b;
        logic [3:0]  cur_a;
        logic [3:0]  cur_b;
        logic        a_pos;
        logic        a_neg;
        logic        b_pos;
        logic        b_neg;
        logic        br_en;
    } spd_state_t;

    spd_state_t st_ff;
    spd_state_t nxt_st;
    logic       tsd_rise;

    // Reload value of the reset pulse timer, cut to the counter width on purpose.
    localparam logic [20:0] PULSE_LOAD = 21'(RST_PULSE_CYC);

    assign tsd_rise = thermal_shutdown && !st_ff.tsd_q;

    // Register updates, thermal handling and output decode in one pass.
    // Outputs are decoded from the next register values so that a completed
    // write reaches the bridge pins on the very next edge with no extra stage.
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.tsd_q = thermal_shutdown;

        // Host writes; the receiver already drops frames sent during sleep.
        if (word_vld && word_sel == spd_pkg::SEL_PARAM) begin
            nxt_st.param = word_data;
        end
        if (word_vld && word_sel == spd_pkg::SEL_EXT) begin
            nxt_st.tsel = word_data[spd_pkg::TSEL_LSB +: 3];
        end

        // Reset pulse timer keeps running to the end of its 40 ms.
        if (st_ff.pulse_cnt != '0) begin
            nxt_st.pulse_cnt = st_ff.pulse_cnt - 21'h00_0001;
        end

        // Thermal trip.
        if (tsd_rise) begin
            nxt_st.motor_sd = 1'b1;
            if (is_tsd_ctrl(st_ff.tsel)) begin
                nxt_st.param = st_ff.param;
                nxt_st.tsel  = st_ff.tsel;
                if (st_ff.tsel == spd_pkg::TSEL_TSD2 && st_ff.pulse_cnt == '0) begin
                    nxt_st.pulse_cnt = PULSE_LOAD;
                end
            end else begin
                // Outside modes 001 and 010 a trip drops the whole supply tree.
                nxt_st.buck_en = 1'b0;
                nxt_st.param   = spd_pkg::PARAM_RST;
                nxt_st.tsel    = spd_pkg::TSEL_RST;
            end
        end

        // Sleep clears both registers and releases a thermal stop; the pulse timer runs on.
        if (!sleep_n_input) begin
            nxt_st.param    = spd_pkg::PARAM_RST;
            nxt_st.tsel     = spd_pkg::TSEL_RST;
            nxt_st.motor_sd = tsd_rise;           // A trip in the same cycle wins.
            nxt_st.buck_en  = 1'b1;
        end

        // Reset output is high while no pulse runs; only a mode 010 trip starts one.
        nxt_st.rst_n = (nxt_st.pulse_cnt == '0);

        // Oscillator monitor.
        nxt_st.osc_mon = (nxt_st.tsel == spd_pkg::TSEL_OSCMON) && osc_clk_in;

        // Drive field decode.
        nxt_st.torque  = nxt_st.param[spd_pkg::TORQUE_LSB +: 2];
        nxt_st.decay_b = nxt_st.param[spd_pkg::DECAY_B_LSB +: 2];
        nxt_st.decay_a = nxt_st.param[spd_pkg::DECAY_A_LSB +: 2];
        nxt_st.cur_b   = nxt_st.param[spd_pkg::CUR_B_LSB +: 4];
        nxt_st.cur_a   = nxt_st.param[spd_pkg::CUR_A_LSB +: 4];

        // Both legs of a winding go low while the bridges are off.
        nxt_st.br_en = sleep_n_input && !nxt_st.motor_sd;
        nxt_st.b_pos = nxt_st.br_en && nxt_st.param[spd_pkg::DIR_B_BIT];
        nxt_st.b_neg = nxt_st.br_en && !nxt_st.param[spd_pkg::DIR_B_BIT];
        nxt_st.a_pos = nxt_st.br_en && nxt_st.param[spd_pkg::DIR_A_BIT];
        nxt_st.a_neg = nxt_st.br_en && !nxt_st.param[spd_pkg::DIR_A_BIT];
    end

    // Single state register; reset values are the register defaults.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff         <= '0;
            st_ff.buck_en <= 1'b1;
            st_ff.rst_n   <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =========================================================================
    // Outputs
    assign torque_sel            = st_ff.torque;
    assign decay_a_mode          = st_ff.decay_a;
    assign decay_b_mode          = st_ff.decay_b;
    assign current_a_level       = st_ff.cur_a;
    assign current_b_level       = st_ff.cur_b;
    assign winding_a_pos_out     = st_ff.a_pos;
    assign winding_a_neg_out     = st_ff.a_neg;
    assign winding_b_pos_out     = st_ff.b_pos;
    assign winding_b_neg_out     = st_ff.b_neg;
    assign motor_bridge_en       = st_ff.br_en;
    assign buck_enable           = st_ff.buck_en;
    assign reset_out_n           = st_ff.rst_n;
    assign test_select           = st_ff.tsel;
    assign dcdc_osc_monitor_pin  = st_ff.osc_mon;
    assign motor_osc_monitor_pin = st_ff.osc_mon;

    // =========================================================================
    // Checks
    a_sleep_clears: assert property (@(posedge clk) disable iff (rst)
        !sleep_n_input |=> (st_ff.param == '0) && (st_ff.tsel == '0) && !motor_bridge_en)
        else $error("sleep did not clear the registers");

    a_tsd_keeps: assert property (@(posedge clk) disable iff (rst)
        (tsd_rise && is_tsd_ctrl(st_ff.tsel) && sleep_n_input && !word_vld)
        |=> buck_enable && $stable(st_ff.param) && !motor_bridge_en)
        else $error("confined thermal trip disturbed registers or supply");

    a_mode1_no_rst: assert property (@(posedge clk) disable iff (rst)
        (tsd_rise && st_ff.tsel == spd_pkg::TSEL_TSD1 && st_ff.pulse_cnt == '0)
        |=> reset_out_n [*4])
        else $error("reset output pulsed in mode 001");

    a_mode2_pulse: assert property (@(posedge clk) disable iff (rst)
        (tsd_rise && st_ff.tsel == spd_pkg::TSEL_TSD2 && st_ff.pulse_cnt == '0)
        |=> !reset_out_n && (st_ff.pulse_cnt == PULSE_LOAD))
        else $error("mode 010 thermal trip did not start reset pulse");

    a_pulse_end: assert property (@(posedge clk) disable iff (rst)
        (st_ff.pulse_cnt == 21'h00_0001) |=> reset_out_n)
        else $error("reset pulse outlasted its count");

    a_osc_mon: assert property (@(posedge clk) disable iff (rst)
        (st_ff.tsel == spd_pkg::TSEL_OSCMON && sleep_n_input && !word_vld && !tsd_rise)
        |=> dcdc_osc_monitor_pin == $past(osc_clk_in)
            && motor_osc_monitor_pin == $past(osc_clk_in))
        else $error("oscillator not routed to monitor pins");

    a_dir_b: assert property (@(posedge clk) disable iff (rst)
        motor_bridge_en |-> winding_b_pos_out == st_ff.param[spd_pkg::DIR_B_BIT]
                         && winding_b_neg_out == !st_ff.param[spd_pkg::DIR_B_BIT])
        else $error("winding B direction wrong");

    a_dir_a: assert property (@(posedge clk) disable iff (rst)
        motor_bridge_en |-> winding_a_pos_out == st_ff.param[spd_pkg::DIR_A_BIT]
                         && winding_a_neg_out == !st_ff.param[spd_pkg::DIR_A_BIT])
        else $error("winding A direction wrong");

    a_apply_write: assert property (@(posedge clk) disable iff (rst)
        (word_vld && word_sel == spd_pkg::SEL_PARAM && sleep_n_input && !tsd_rise)
        |=> torque_sel == $past(word_data[1:0]) && current_a_level == $past(word_data[14:11])
            && decay_b_mode == $past(word_data[3:2]) && current_b_level == $past(word_data[7:4]))
        else $error("written fields not applied on next edge");

endmodule : spd_top

// File: shared/spd_pkg.sv
package spd_pkg;

    // =========================================================================
    // Register layout
    localparam int unsigned PARAM_W      = 16;
    localparam int unsigned FRAME_W      = 17;
    localparam logic [15:0] PARAM_RST    = 16'h0000;
    localparam logic [2:0]  TSEL_RST     = 3'h0;
    localparam int unsigned TORQUE_LSB   = 0;
    localparam int unsigned DECAY_B_LSB  = 2;
    localparam int unsigned CUR_B_LSB    = 4;
    localparam int unsigned DIR_B_BIT    = 8;
    localparam int unsigned DECAY_A_LSB  = 9;
    localparam int unsigned CUR_A_LSB    = 11;
    localparam int unsigned DIR_A_BIT    = 15;
    localparam int unsigned TSEL_LSB     = 13;

    // Frame select bit values: first bit shifted in names the target register.
    localparam logic        SEL_PARAM    = 1'b0;
    localparam logic        SEL_EXT      = 1'b1;

    // =========================================================================
    // Test select codes
    localparam logic [2:0]  TSEL_NORMAL  = 3'h0;
    localparam logic [2:0]  TSEL_TSD1    = 3'h1;
    localparam logic [2:0]  TSEL_TSD2    = 3'h2;
    localparam logic [2:0]  TSEL_OSCMON  = 3'h3;

    // =========================================================================
    // Timing
    localparam int unsigned CLK_KHZ      = 40_000;
    localparam int unsigned RST_PULSE_MS = 40;
    localparam int unsigned RST_PULSE_CYC = RST_PULSE_MS * CLK_KHZ;
    localparam int unsigned PULSE_CNT_W  = 21;

endpackage : spd_pkg

// File: testbench/spd_host_model.sv
`timescale 1ns/10ps
module spd_host_model (
    // Clock
    input  wire logic clk,
    // Three-wire serial pins
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_latch
);
    // =====================================================================
    // Idle levels before the first frame.
    initial begin
        ser_clk   = 1'b0;
        ser_data  = 1'b0;
        ser_latch = 1'b0;
    end

    // Select bit, then data MSB first, one bit per serial clock rise, then latch.
    // Data is held through the high phase so the rise always sees a settled bit.
    task automatic send(input logic sel, input logic [15:0] data);
        logic [16:0] frame;
        frame = {sel, data};
        for (int i = 16; i >= 0; i--) begin
            @(posedge clk);
            ser_clk  <= 1'b0;
            ser_data <= frame[i];
            @(posedge clk);
            ser_clk  <= 1'b1;
        end
        @(posedge clk);
        ser_clk   <= 1'b0;
        ser_latch <= 1'b1;
        @(posedge clk);
        ser_latch <= 1'b0;
        // The data line is undriven after a frame, so show the opposite level.
        ser_data  <= ~frame[0];
    endtask : send
endmodule : spd_host_model

// File: testbench/stepper_param_and_test_select_tb_top.sv
`timescale 1ns/10ps
module stepper_param_and_test_select_tb_top;
    // Short reset pulse so the run stays brief.
    localparam int unsigned PULSE = 20;
    logic       clk, rst, sleep_n_input, thermal_shutdown, osc_clk_in;
    logic       ser_clk, ser_data, ser_latch;
    logic [1:0] torque_sel, decay_a_mode, decay_b_mode;
    logic [3:0] current_a_level, current_b_level;
    logic       winding_a_pos_out, winding_a_neg_out, winding_b_pos_out, winding_b_neg_out;
    logic       motor_bridge_en, buck_enable, reset_out_n;
    logic [2:0] test_select;
    logic       dcdc_osc_monitor_pin, motor_osc_monitor_pin;
    logic [15:0] v;
    int         n_fail, checked, lows;

    // =====================================================================
    // Design and host model.
    spd_top #(.RST_PULSE_CYC(PULSE)) i_spd_top (
        .clk(clk), .rst(rst), .sleep_n_input(sleep_n_input),
        .thermal_shutdown(thermal_shutdown), .osc_clk_in(osc_clk_in),
        .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch),
        .torque_sel(torque_sel), .decay_a_mode(decay_a_mode), .decay_b_mode(decay_b_mode),
        .current_a_level(current_a_level), .current_b_level(current_b_level),
        .winding_a_pos_out(winding_a_pos_out), .winding_a_neg_out(winding_a_neg_out),
        .winding_b_pos_out(winding_b_pos_out), .winding_b_neg_out(winding_b_neg_out),
        .motor_bridge_en(motor_bridge_en), .buck_enable(buck_enable),
        .reset_out_n(reset_out_n), .test_select(test_select),
        .dcdc_osc_monitor_pin(dcdc_osc_monitor_pin),
        .motor_osc_monitor_pin(motor_osc_monitor_pin));
    spd_host_model i_spd_host_model (
        .clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));

    // Clock and a fast oscillator stand-in that toggles every cycle.
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    always @(posedge clk) osc_clk_in <= rst ? 1'b0 : ~osc_clk_in;

    // =====================================================================
    // Helpers: wait and settle, compare, write, verdict.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic sel, input logic [15:0] d);
        i_spd_host_model.send(sel, d);
        cyc(3);
    endtask : wr

    task automatic chk_param(input logic [15:0] p);
        chk(torque_sel, p[1:0]);
        chk(decay_b_mode, p[3:2]);
        chk(current_b_level, p[7:4]);
        chk({winding_b_pos_out, winding_b_neg_out}, {p[8], ~p[8]});
        chk(decay_a_mode, p[10:9]);
        chk(current_a_level, p[14:11]);
        chk({winding_a_pos_out, winding_a_neg_out}, {p[15], ~p[15]});
    endtask : chk_param

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // Watchdog sized well beyond the roughly 640 cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end

    // =====================================================================
    // Test sequence.
    initial begin
        rst = 1'b1;
        sleep_n_input = 1'b1;
        thermal_shutdown = 1'b0;
        n_fail = 0;
        checked = 0;
        cyc(4);
        @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        chk_param(16'h0000);
        chk(test_select, spd_pkg::TSEL_RST);
        chk(dcdc_osc_monitor_pin, 1'b0);
        $display("test reset state done");
        // Every torque and decay code, including the two the host should avoid.
        for (int i = 0; i < 4; i++) begin
            v = {i[0], 4'(i * 5), 2'(i), ~i[0], 4'(15 - i * 3), 2'(3 - i), 2'(i)};
            wr(spd_pkg::SEL_PARAM, v);
            chk_param(v);
        end
        $display("test parameter fields done");
        // Sleep clears both registers and blocks writes until it rises again.
        wr(spd_pkg::SEL_EXT, {spd_pkg::TSEL_OSCMON, 13'h0000});
        @(posedge clk);
        sleep_n_input <= 1'b0;
        cyc(2);
        chk(test_select, 3'h0);
        chk(torque_sel, 2'b00);
        wr(spd_pkg::SEL_PARAM, 16'hFFFF);
        @(posedge clk);
        sleep_n_input <= 1'b1;
        cyc(2);
        chk_param(16'h0000);
        $display("test sleep clear done");
        // Thermal trip in modes 000, 001 and 010.
        for (int m = 0; m < 3; m++) begin
            wr(spd_pkg::SEL_EXT, {3'(m), 13'h0000});
            chk(test_select, 3'(m));
            wr(spd_pkg::SEL_PARAM, 16'h8F5F);
            @(posedge clk);
            thermal_shutdown <= 1'b1;
            lows = 0;
            repeat (PULSE + 10) begin
                cyc(1);
                lows += (reset_out_n === 1'b0);
            end
            chk(motor_bridge_en, 1'b0);
            chk(buck_enable, m != 0);
            chk(torque_sel, (m == 0) ? 2'b00 : 2'b11);
            chk(16'(lows), (m == 2) ? 16'(PULSE) : 16'h0000);
            @(posedge clk);
            thermal_shutdown <= 1'b0;
            sleep_n_input <= 1'b0;
            cyc(2);
            @(posedge clk);
            sleep_n_input <= 1'b1;
            cyc(2);
            chk({motor_bridge_en, buck_enable, reset_out_n}, 3'b111);
            $display("test thermal mode %0d done", m);
        end
        // Oscillator monitor: both pins follow the clock one cycle late.
        wr(spd_pkg::SEL_EXT, {spd_pkg::TSEL_OSCMON, 13'h0000});
        repeat (4) begin
            cyc(1);
            chk({dcdc_osc_monitor_pin, motor_osc_monitor_pin}, {2{~osc_clk_in}});
        end
        $display("test oscillator monitor done");
        print_verdict();
    end
endmodule : stepper_param_and_test_select_tb_top
